/* File: core/ring_ctrl_device.sv */
/*
 Controller end: command strobes, main status word, interrupt, reset chain.
 Assumes FIFO flags and receive events come from logic on the same clock,
 and the lock signal of the timing receiver comes from a pin.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module ring_ctrl_device
   import ring_regs_pkg::*;
#(
   parameter int RESET_CYC = RING_RESET_CYC,
   parameter int IDLE_NUM  = IDLE_BYTES
) (
   input  wire logic               clk_i,
   input  wire logic               rstn_i,
   input  wire logic               ce_i,
   ring_reg_if.device              bus,
   input  wire logic               timing_clock_locked_i,
   input  wire logic               send_enable_i,
   input  wire logic               send_cmd_i,
   input  wire logic               eof_sent_i,
   input  wire logic               idle_byte_sent_i,
   input  wire logic               token_rx_i,
   input  wire logic               rx_wr_i,
   input  wire logic               rx_last_i,
   input  wire logic               rx_for_ctrl_i,
   input  wire logic               rx_frame_data_i,
   input  wire logic [15:0]        rx_data_i,
   input  wire logic               tx_empty_i,
   input  wire logic               tx_full_i,
   input  wire logic               ret_empty_i,
   input  wire logic               ret_full_i,
   input  wire logic               rx_empty_i,
   input  wire logic               rx_full_i,
   input  wire logic [15:0]        tx_fifo_q_i,
   input  wire logic [15:0]        ret_fifo_q_i,
   output logic                    ring_reset_o,
   output logic                    timing_receiver_reset_o,
   output logic                    abandon_wait_emit_token_o,
   output logic [ERR_W-1:0]        err_clear_o,
   output logic                    ret_wr_o,
   output logic [15:0]             ret_data_o,
   output logic [15:0]             tx_host_data_o,
   output logic [15:0]             ret_host_data_o
);

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   function automatic logic [15:0] guard_empty(input logic empty, input logic [15:0] q);
      guard_empty = empty ? EMPTY_READ : q;
   endfunction : guard_empty

   logic                lreset;
   logic                cmd_wr;
   logic                status_rd;
   logic                clr_irq;
   logic                msg_end;
   logic                any_end;
   logic                idle_done;
   logic [15:0]         status_w;

   logic                ring_reset_q;
   logic [7:0]          reset_cnt_q;
   logic                trx_reset_q;
   logic                lock_s1_q;
   logic                lock_s2_q;
   logic                lock_s3_q;
   logic                locked_q;
   logic                msg_q;
   logic                pend_q;
   logic                link_up_q;
   logic [IDLE_W-1:0]   idle_cnt_q;
   logic                tx_run_q;
   logic                release_q;
   logic [ERR_W-1:0]    err_clear_q;
   logic                ret_wr_q;
   logic [15:0]         ret_data_q;
   logic [15:0]         tx_host_q;
   logic [15:0]         ret_host_q;
   logic [15:0]         rdata_q;

   assign lreset    = !bus.local_reset_n;
   assign cmd_wr    = bus.wr && (bus.addr == CMD_OFF);              // see [R7]
   assign status_rd = bus.rd && (bus.addr == STATUS_OFF);
   assign clr_irq   = cmd_wr && bus.wdata[CMD_CLR_IRQ];
   assign msg_end   = rx_wr_i && rx_last_i && rx_for_ctrl_i;
   assign any_end   = rx_wr_i && rx_last_i;
   assign idle_done = (idle_cnt_q == IDLE_W'(IDLE_NUM));

   // Status word; nothing in it is writable, so writes to it decode to nothing
   always_comb begin                                                // see [R12]
      status_w               = ZERO_WORD;                            // see [R24]
      status_w[ST_LOCKED]    = locked_q;                             // see [R13]
      status_w[ST_MSG_CTRL]  = msg_q;                                // see [R14]
      status_w[ST_PEND_IRQ]  = pend_q;                               // see [R16]
      status_w[ST_LINK_UP]   = link_up_q;                            // see [R17]
      status_w[ST_TX_EMPTY]  = tx_empty_i;                           // see [R18]
      status_w[ST_TX_FULL]   = tx_full_i;                            // see [R19]
      status_w[ST_RET_EMPTY] = ret_empty_i;                          // see [R20]
      status_w[ST_RET_FULL]  = ret_full_i;                           // see [R20]
      status_w[ST_RX_EMPTY]  = rx_empty_i;                           // see [R21]
      status_w[ST_RX_FULL]   = rx_full_i;                            // see [R21]
      status_w[ST_RX_RUN]    = rx_frame_data_i;                      // see [R22]
      status_w[ST_TX_RUN]    = tx_run_q;                             // see [R23]
   end

   // ----------------------------------------------------------------
   // Reset chain
   // ----------------------------------------------------------------
   // Ring reset stretched to its minimum width after the bridge lets go
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reset_cnt_q  <= 8'h00;
         ring_reset_q <= 1'b1;
         trx_reset_q  <= 1'b1;
      end else if (ce_i) begin
         reset_cnt_q  <= lreset ? 8'(RESET_CYC) :
                         (reset_cnt_q != 8'h00) ? reset_cnt_q - 8'h01 : 8'h00; // see [R1]
         ring_reset_q <= lreset || (reset_cnt_q > 8'h01);             // see [R1]
         trx_reset_q  <= lreset;                                      // see [R1]
      end
   end

   // ----------------------------------------------------------------
   // Lock synchroniser
   // ----------------------------------------------------------------
   // Counted only when the last two stages agree, which filters one-cycle glitches
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lock_s1_q <= 1'b0;
         lock_s2_q <= 1'b0;
         lock_s3_q <= 1'b0;
         locked_q  <= 1'b0;
      end else if (ce_i) begin
         lock_s1_q <= timing_clock_locked_i;
         lock_s2_q <= lock_s1_q;
         lock_s3_q <= lock_s2_q;
         if (lock_s2_q == lock_s3_q) begin
            locked_q <= lock_s3_q;                                    // see [R13]
         end
      end
   end

   // ----------------------------------------------------------------
   // Sticky flags and interrupt
   // ----------------------------------------------------------------
   // A message end in the clearing cycle wins over the clear
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         msg_q      <= 1'b0;
         pend_q     <= 1'b0;
         link_up_q  <= 1'b0;
         idle_cnt_q <= '0;
         tx_run_q   <= 1'b0;
      end else if (ce_i) begin
         if (lreset) begin                                           // see [R1]
            msg_q      <= 1'b0;
            pend_q     <= 1'b0;
            link_up_q  <= 1'b0;
            idle_cnt_q <= '0;
            tx_run_q   <= 1'b0;
         end else begin
            msg_q  <= msg_end || (msg_q && !clr_irq);                // see [R10] see [R14]
            pend_q <= any_end || (pend_q && !clr_irq);               // see [R11] see [R16]
            if (idle_byte_sent_i && !idle_done) begin
               idle_cnt_q <= idle_cnt_q + IDLE_W'(1);                // see [R17]
            end
            if (idle_done && token_rx_i) begin
               link_up_q <= 1'b1;                                    // see [R17]
            end
            tx_run_q <= (send_enable_i && send_cmd_i) ||
                        (tx_run_q && !(tx_empty_i && eof_sent_i));   // see [R23]
         end
      end
   end

   // ----------------------------------------------------------------
   // One-shot commands, data copies and read port
   // ----------------------------------------------------------------
   // Command bits are never stored: they live one cycle as pulses
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         release_q   <= 1'b0;
         err_clear_q <= '0;
         ret_wr_q    <= 1'b0;
         ret_data_q  <= ZERO_WORD;
         tx_host_q   <= EMPTY_READ;
         ret_host_q  <= EMPTY_READ;
         rdata_q     <= ZERO_WORD;
      end else if (ce_i) begin
         release_q   <= cmd_wr && bus.wdata[CMD_RELEASE] && !lreset;  // see [R7] see [R8]
         err_clear_q <= (cmd_wr && bus.wdata[CMD_CLR_ERR] ? ERR_LOW_MASK : '0) |
                        (clr_irq ? ERR_MID_MASK : '0);                // see [R9] see [R10]
         ret_wr_q    <= rx_wr_i && rx_for_ctrl_i && !lreset;          // see [R15]
         ret_data_q  <= rx_data_i;                                    // see [R15]
         tx_host_q   <= guard_empty(tx_empty_i, tx_fifo_q_i);         // see [R18]
         ret_host_q  <= guard_empty(ret_empty_i, ret_fifo_q_i);       // see [R20]
         rdata_q     <= status_rd ? status_w : ZERO_WORD;             // see [R7] see [R12]
      end
   end

   assign ring_reset_o              = ring_reset_q;
   assign timing_receiver_reset_o   = trx_reset_q;
   assign abandon_wait_emit_token_o = release_q;
   assign err_clear_o               = err_clear_q;
   assign ret_wr_o                  = ret_wr_q;
   assign ret_data_o                = ret_data_q;
   assign tx_host_data_o            = tx_host_q;
   assign ret_host_data_o           = ret_host_q;
   assign bus.rdata                 = rdata_q;
   assign bus.irq                   = pend_q;                         // see [R11] see [R16]

endmodule : ring_ctrl_device

/* File: core/ring_ctrl_host.sv */
/*
 Bridge end: forwards software register accesses to the controller, holds the
 bridge control register and sequences local reset, reload and dead time.
 Assumes software uses the plain strobe port and watches busy_o.
*/
`timescale 1ns/10ps
module ring_ctrl_host
   import ring_regs_pkg::*;
#(
   parameter int LRESET_CYC = 4,
   parameter int RELOAD_CYC = 64,
   parameter int DEAD_CNT   = DEAD_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        ce_i,
   ring_reg_if.host         bus,
   input  wire logic        req_cfg_i,
   input  wire logic [7:0]  req_addr_i,
   input  wire logic [31:0] req_wdata_i,
   input  wire logic        req_wr_i,
   input  wire logic        req_rd_i,
   input  wire logic        ext_clock_sel_i,
   input  wire logic        reload_jumper_i,
   output logic [31:0]      req_rdata_o,
   output logic             busy_o,
   output logic             refused_o,
   output logic             irq_o
);

   host_state_t  state_q;
   logic [31:0]  cnt_q;
   logic [31:0]  bridge_ctrl_q;
   logic [31:0]  saved_q;
   logic [31:0]  cfg_rdata_q;
   logic         rd_cfg_q;
   logic         rd_stat_q;
   logic         locked_seen_q;
   logic         lreset_n_q;
   logic         refused_q;

   logic         running;
   logic         cfg_wr;
   logic         toggle;
   logic         ring_rst_wr;
   logic         local_ok;
   logic         cnt_done;

   assign running     = (state_q == HS_RUN);
   assign cfg_wr      = req_wr_i && req_cfg_i && (req_addr_i == BRIDGE_CTRL_OFF);
   assign toggle      = cfg_wr && running &&
                        (req_wdata_i[BRIDGE_RESET_BIT] != bridge_ctrl_q[BRIDGE_RESET_BIT]);
   // Either ring reset bit blocked, when the external clock is selected, until the timing clock is seen locked
   assign ring_rst_wr = req_wr_i && (req_addr_i == CTRL0_OFF) && ext_clock_sel_i &&
                        !locked_seen_q &&
                        (req_wdata_i[CTRL0_RST_OUT] || req_wdata_i[CTRL0_RST_B]); // see [R6]
   assign local_ok    = running && !req_cfg_i && !ring_rst_wr;                    // see [R3]
   assign cnt_done    = (cnt_q == 32'h0000_0001);

   assign bus.local_reset_n = lreset_n_q;
   assign bus.addr          = req_addr_i;
   assign bus.wdata         = req_wdata_i[15:0];
   assign bus.wr            = req_wr_i && local_ok;
   assign bus.rd            = req_rd_i && local_ok;

   // ----------------------------------------------------------------
   // Reset sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q       <= HS_RUN;
         cnt_q         <= 32'h0000_0000;
         bridge_ctrl_q <= BRIDGE_CTRL_DEFAULT;
         saved_q       <= BRIDGE_CTRL_DEFAULT;
         lreset_n_q    <= 1'b1;
      end else if (ce_i) begin
         case (state_q)
            HS_RUN: begin
               if (cfg_wr) begin
                  bridge_ctrl_q <= req_wdata_i;
                  saved_q       <= req_wdata_i;
               end
               if (toggle) begin                                      // see [R2]
                  state_q    <= HS_LRESET;
                  cnt_q      <= 32'(LRESET_CYC);
                  lreset_n_q <= 1'b0;
               end
            end
            HS_LRESET: begin
               cnt_q <= cnt_q - 32'h0000_0001;
               if (cnt_done) begin
                  state_q       <= HS_RELOAD;
                  cnt_q         <= 32'(RELOAD_CYC);
                  lreset_n_q    <= 1'b1;
                  bridge_ctrl_q <= BRIDGE_CTRL_DEFAULT;
               end
            end
            HS_RELOAD: begin
               cnt_q <= cnt_q - 32'h0000_0001;
               if (cnt_done) begin                                    // see [R3]
                  bridge_ctrl_q <= saved_q;                           // see [R4]
                  state_q       <= reload_jumper_i ? HS_DEAD : HS_RUN;
                  cnt_q         <= 32'(DEAD_CNT);
               end
            end
            HS_DEAD: begin
               cnt_q <= cnt_q - 32'h0000_0001;
               if (cnt_done) begin                                    // see [R5]
                  state_q <= HS_RUN;
               end
            end
            default: begin
               state_q <= HS_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read return and lock tracking
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_cfg_q      <= 1'b0;
         rd_stat_q     <= 1'b0;
         cfg_rdata_q   <= 32'h0000_0000;
         locked_seen_q <= 1'b0;
         refused_q     <= 1'b0;
      end else if (ce_i) begin
         rd_cfg_q    <= req_rd_i && req_cfg_i;
         rd_stat_q   <= req_rd_i && local_ok && (req_addr_i == STATUS_OFF);
         cfg_rdata_q <= (req_addr_i == BRIDGE_CTRL_OFF) ? bridge_ctrl_q : 32'h0000_0000;
         refused_q   <= (req_wr_i || req_rd_i) && !req_cfg_i && !local_ok;
         if (toggle) begin
            locked_seen_q <= 1'b0;
         end else if (rd_stat_q) begin
            locked_seen_q <= bus.rdata[ST_LOCKED];                    // see [R6]
         end
      end
   end

   assign req_rdata_o = rd_cfg_q ? cfg_rdata_q : {16'h0000, bus.rdata};
   assign busy_o      = !running;
   assign refused_o   = refused_q;
   assign irq_o       = bus.irq;

endmodule : ring_ctrl_host

/* File: core/ring_reg_if.sv */
/*
 Link between bridge end and controller end: local reset, register
 strobes, read data and the level interrupt.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface ring_reg_if;
   logic        local_reset_n;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        irq;

   modport device (
      input  local_reset_n,
      input  addr,
      input  wdata,
      input  wr,
      input  rd,
      output rdata,
      output irq
   );

   modport host (
      output local_reset_n,
      output addr,
      output wdata,
      output wr,
      output rd,
      input  rdata,
      input  irq
   );
endinterface : ring_reg_if

/* File: core/ring_regs_pkg.sv */
/*
 Constants shared by both ends of the ring controller register link:
 register offsets, status and command bit positions, reset values and timing.
 Assumes a 20 MHz clock common to both ends.
*/
// What this block does
// [R1] Bridge local reset resets logic, drives both resets
// [R2] Host toggles bridge control bit 30 for reset
// [R3] Host waits for bridge reload before access
// [R4] Host rewrites non-default bridge settings after reload
// [R5] Host waits 0.5 s when reload jumper set
// [R6] No ring reset writes before clock locked; the bridge blocks them only while the external clock is selected
// [R7] Command register write-only, bits self-clear
// [R8] Command bit 2 emits token, stops waiting
// [R9] Command bit 1 clears error bits 2:0
// [R10] Command bit 0 clears 13:12, errors 6:3
// [R11] Interrupt is level, held until host clears
// [R12] Status register read-only, writes ignored
// [R13] Status bit 14 shows timing clock locked
// [R14] Bit 13 set on controller message end
// [R15] Controller messages also copied to return FIFO
// [R16] Interrupt on any message end; bit 12 mirrors
// [R17] Bit 11 after 512 idle bytes, token
// [R18] Bit 10 transmit empty; empty read gives FFFF
// [R19] Bit 9 transmit FIFO full
// [R20] Bits 7,6 return empty/full; empty reads ones
// [R21] Bits 4,3 receive FIFO empty/full
// [R22] Bit 1 high while frame data received
// [R23] Bit 0 transmit running until empty, EOF
// [R24] Unused status bits read as zero
package ring_regs_pkg;

   // ----------------------------------------------------------------
   // Local register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 16;
   localparam logic [7:0]  CTRL0_OFF   = 8'h00;
   localparam logic [7:0]  CMD_OFF     = 8'h04;
   localparam logic [7:0]  STATUS_OFF  = 8'h08;

   // ----------------------------------------------------------------
   // Command and status bits
   // ----------------------------------------------------------------
   localparam int CMD_CLR_IRQ    = 0;
   localparam int CMD_CLR_ERR    = 1;
   localparam int CMD_RELEASE    = 2;
   localparam int ERR_W          = 7;
   localparam logic [6:0] ERR_LOW_MASK = 7'h07;
   localparam logic [6:0] ERR_MID_MASK = 7'h78;

   localparam int ST_TX_RUN      = 0;
   localparam int ST_RX_RUN      = 1;
   localparam int ST_RX_FULL     = 3;
   localparam int ST_RX_EMPTY    = 4;
   localparam int ST_RET_FULL    = 6;
   localparam int ST_RET_EMPTY   = 7;
   localparam int ST_TX_FULL     = 9;
   localparam int ST_TX_EMPTY    = 10;
   localparam int ST_LINK_UP     = 11;
   localparam int ST_PEND_IRQ    = 12;
   localparam int ST_MSG_CTRL    = 13;
   localparam int ST_LOCKED      = 14;
   localparam int CTRL0_RST_OUT  = 15;
   localparam int CTRL0_RST_B    = 9;
   localparam logic [15:0] EMPTY_READ = 16'hFFFF;
   localparam logic [15:0] ZERO_WORD  = 16'h0000;

   // ----------------------------------------------------------------
   // Bridge configuration space
   // ----------------------------------------------------------------
   localparam logic [7:0]  BRIDGE_CTRL_OFF     = 8'h6C;
   localparam int          BRIDGE_RESET_BIT    = 30;
   localparam logic [31:0] BRIDGE_CTRL_DEFAULT = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ           = 20000;
   localparam int RING_RESET_NS     = 400;
   localparam int RING_RESET_CYC    = (RING_RESET_NS * CLK_KHZ + 999999) / 1000000;
   localparam int DEAD_TIME_MS      = 500;
   localparam int DEAD_CYC          = DEAD_TIME_MS * CLK_KHZ;
   localparam int IDLE_BYTES        = 512;
   localparam int IDLE_W            = 10;

   typedef enum logic [1:0] {
      HS_RUN    = 2'b00,
      HS_LRESET = 2'b01,
      HS_RELOAD = 2'b11,
      HS_DEAD   = 2'b10
   } host_state_t;

endpackage : ring_regs_pkg

/* File: tb/ring_link_assertions.sv */
/*
 Checker for the register link between the bridge end and the controller end.
 Assumes one clock and the ring_reg_if signals as plain inputs.
*/
`timescale 1ns/10ps
module ring_link_assertions
   import ring_regs_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        local_reset_n,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [15:0] rdata,
   input  wire logic        irq
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   wire st_rd = rd && addr == STATUS_OFF;
   wire clr   = wr && addr == CMD_OFF && wdata[CMD_CLR_IRQ];
   property p_cmd_wo; rd && addr == CMD_OFF |=> rdata == 16'h0000; endproperty
   property p_idle_zero; !rd |=> rdata == 16'h0000; endproperty
   property p_unused; st_rd |=> (rdata & 16'h8124) == 16'h0000; endproperty
   property p_mirror; st_rd |=> rdata[ST_PEND_IRQ] == $past(irq); endproperty
   property p_msg_irq; st_rd |=> !rdata[ST_MSG_CTRL] || rdata[ST_PEND_IRQ]; endproperty
   // A new message end in the clearing cycle would win; the bench avoids it
   property p_clear; clr |=> !irq; endproperty
   property p_hold; irq && local_reset_n && !clr |=> irq; endproperty
   property p_lreset; !local_reset_n |=> !irq; endproperty
   a_cmd_wo: assert property (p_cmd_wo) else $error("command register read back");
   a_idle_zero: assert property (p_idle_zero) else $error("read data outside a read");
   a_unused: assert property (p_unused) else $error("unused status bit set");
   a_mirror: assert property (p_mirror) else $error("bit 12 differs from irq");
   a_msg_irq: assert property (p_msg_irq) else $error("bit 13 without bit 12");
   a_clear: assert property (p_clear) else $error("irq not cleared");
   a_hold: assert property (p_hold) else $error("irq dropped by itself");
   a_lreset: assert property (p_lreset) else $error("irq kept in local reset");
   c_irq: cover property ($rose(irq));
   c_clr: cover property (clr ##1 !irq);
   c_lres: cover property ($fell(local_reset_n));
endmodule : ring_link_assertions

/* File: tb/tb.sv */
/*
 Testbench: both ends joined by ring_reg_if, driven from both sides.
 Assumes 20 MHz clock, IDLE_NUM 4 and DEAD_CNT 20 to keep the run short.
*/
`timescale 1ns/10ps
module tb;
   import ring_regs_pkg::*;
   logic        clk_i = 0, rstn_i = 0, cfg = 0, wr = 0, rd = 0, xsel = 0, jmp = 0, ce = 1;
   logic [7:0]  a  = 0;
   logic [31:0] wd = 0, d;
   logic [9:0]  ev = 0;
   logic [5:0]  fl = 6'h05;
   logic [15:0] rx_data = 16'hABCD, txq = 16'h1234;
   wire  [31:0] rdata;
   wire         busy, refused, irq, ring_rst, trx_rst, abandon, ret_wr;
   wire  [6:0]  errc;
   wire  [15:0] ret_data, tx_hd, ret_hd;
   int          n_mismatch = 0, num_checks = 0, cnt, base;
   int          pos [6] = '{10, 9, 7, 6, 4, 3};
   always #25 clk_i = ~clk_i;
   ring_reg_if link ();
   ring_ctrl_host #(.LRESET_CYC(4), .RELOAD_CYC(64), .DEAD_CNT(20)) ring_ctrl_host_inst (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .bus(link), .req_cfg_i(cfg), .req_addr_i(a),
      .req_wdata_i(wd), .req_wr_i(wr), .req_rd_i(rd), .ext_clock_sel_i(xsel),
      .reload_jumper_i(jmp), .req_rdata_o(rdata), .busy_o(busy), .refused_o(refused),
      .irq_o(irq));
   ring_ctrl_device #(.IDLE_NUM(4)) ring_ctrl_device_inst (
      .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce), .bus(link), .timing_clock_locked_i(ev[9]),
      .send_enable_i(ev[0]), .send_cmd_i(ev[1]), .eof_sent_i(ev[2]), .idle_byte_sent_i(ev[3]),
      .token_rx_i(ev[4]), .rx_wr_i(ev[5]), .rx_last_i(ev[6]), .rx_for_ctrl_i(ev[7]),
      .rx_frame_data_i(ev[8]), .rx_data_i(rx_data), .tx_empty_i(fl[0]), .tx_full_i(fl[1]),
      .ret_empty_i(fl[2]), .ret_full_i(fl[3]), .rx_empty_i(fl[4]), .rx_full_i(fl[5]),
      .tx_fifo_q_i(txq), .ret_fifo_q_i(txq), .ring_reset_o(ring_rst),
      .timing_receiver_reset_o(trx_rst), .abandon_wait_emit_token_o(abandon),
      .err_clear_o(errc), .ret_wr_o(ret_wr), .ret_data_o(ret_data), .tx_host_data_o(tx_hd),
      .ret_host_data_o(ret_hd));
   ring_link_assertions ring_link_assertions_inst (.clk_i(clk_i), .rstn_i(rstn_i),
      .local_reset_n(link.local_reset_n), .addr(link.addr), .wdata(link.wdata), .wr(link.wr),
      .rd(link.rd), .rdata(link.rdata), .irq(link.irq));
   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk
   // One strobe cycle; answers sampled in the next cycle
   task automatic acc(input logic c, input logic [7:0] ad, input logic [31:0] v, input logic w);
      @(posedge clk_i);
      cfg <= c;
      a   <= ad;
      wd  <= v;
      wr  <= w;
      rd  <= !w;
      @(posedge clk_i);
      wr  <= 0;
      rd  <= 0;
      #1 d = rdata;
   endtask : acc
   task automatic st(input logic [15:0] exp);
      acc(0, STATUS_OFF, 0, 0);
      chk(d, {16'h0000, exp});
   endtask : st
   task automatic pulse(input logic [9:0] m);
      @(posedge clk_i);
      ev <= ev | m;
      @(posedge clk_i);
      ev <= ev & ~m;
      #1;
   endtask : pulse
   task automatic lreset(input logic [31:0] v, output int n);
      acc(1, BRIDGE_CTRL_OFF, v, 1);
      chk(busy, 1);
      acc(0, STATUS_OFF, 0, 0);
      chk({refused, ring_rst, trx_rst}, 3'b111);
      n = 0;
      while (busy !== 1'b0 && n < 500) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk(ring_rst, 0);
   endtask : lreset
   task automatic results();
      $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      rstn_i <= 1;
      repeat (2) @(posedge clk_i);
      #1 chk({ring_rst, trx_rst, busy, irq}, 0);
      chk({tx_hd, ret_hd}, {EMPTY_READ, EMPTY_READ});
      @(posedge clk_i);
      fl <= 0;
      repeat (2) @(posedge clk_i);
      #1 chk({tx_hd, ret_hd}, {txq, txq});
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_i);
         fl <= 6'h01 << i;
         st(16'h0001 << pos[i]);
      end
      @(posedge clk_i);
      fl    <= 0;
      ev[8] <= 1;
      st(16'h0002);
      @(posedge clk_i);
      ev[8] <= 0;
      xsel  <= 1;
      acc(0, CTRL0_OFF, 32'h8000, 1);
      chk(refused, 1);
      @(posedge clk_i);
      ev[9] <= 1;
      repeat (8) @(posedge clk_i);
      st(16'h4000);
      acc(0, CTRL0_OFF, 32'h8000, 1);
      chk(refused, 0);
      $display("test flags done");
      pulse(10'h0E0);
      chk({irq, ret_wr, ret_data}, {2'b11, rx_data});
      st(16'h7000);
      acc(0, CMD_OFF, 32'h2, 1);
      chk({errc, irq}, {7'h07, 1'b1});
      acc(0, CMD_OFF, 32'h1, 1);
      chk({errc, irq}, {7'h78, 1'b0});
      pulse(10'h060);
      st(16'h5000);
      acc(0, CMD_OFF, 32'h5, 1);
      chk({abandon, errc, irq}, {1'b1, 7'h78, 1'b0});
      @(posedge clk_i);
      #1 chk({abandon, errc}, 0);
      acc(0, CMD_OFF, 0, 0);
      chk(d, 0);
      acc(0, STATUS_OFF, 32'hFFFF, 1);
      st(16'h4000);
      $display("test command done");
      repeat (3) pulse(10'h008);
      pulse(10'h010);
      st(16'h4000);
      repeat (4) pulse(10'h008);
      pulse(10'h010);
      st(16'h4800);
      pulse(10'h003);
      pulse(10'h004);
      st(16'h4801);
      @(posedge clk_i);
      ce <= 0;
      pulse(10'h060);
      chk(irq, 0);
      @(posedge clk_i);
      ce <= 1;
      fl <= 6'h01;
      pulse(10'h004);
      st(16'h4C00);
      $display("test link done");
      lreset(32'h4000_0000, cnt);
      st(16'h4400);
      acc(1, BRIDGE_CTRL_OFF, 0, 0);
      chk(d, 32'h4000_0000);
      @(posedge clk_i);
      jmp <= 1;
      lreset(0, base);
      chk(base - cnt, 20);
      $display("test local reset done");
      results();
   end
   // About fifteen times the expected run
   initial begin
      #200000;
      n_mismatch++;
      results();
   end
endmodule : tb
